//--- rtl/hise_irq_ctrl.sv
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// RULE1 - receiver error event sets status bit 14; software writes one to clear
// RULE2 - transmitter error event sets status bit 13; software writes one to clear
// RULE3 - bit 12 is read-only live pin event summary; writes do nothing
// RULE4 - write to full tx data fifo sets overrun bit 10
// RULE5 - tx data free space above threshold sets bit 9
// RULE6 - tx status fifo becoming full sets bit 8
// RULE7 - tx status occupancy reaching threshold sets bit 7
// RULE8 - each dropped received frame sets bit 6
// RULE9 - status write into full rx status fifo sets bit 4
// RULE10 - rx status occupancy reaching threshold sets bit 3
// RULE11 - enable register at 05Ch, 32 bits, set bit lets source drive irq
// RULE12 - status bits record sources regardless of enables, except software bit
// RULE13 - enable bits mirror status positions; reserved positions read-only zero
// RULE14 - enable bits are read/write and reset to zero
// RULE15 - software bit 31 sets when its enable goes high; write one clears
// RULE16 - write-one-to-clear bits stay set until a one is written
// RULE17 - irq high while any status bit and its enable are both set
module hise_irq_ctrl
	import hise_pkg::*;
#(
	parameter int LEVEL_W = LEVEL_W_DEFAULT
) (
	input  wire logic               clk_sys,
	input  wire logic               rst_n,
	input  wire logic [ADDR_W-1:0]  regAddr,
	input  wire logic               regWrite,
	input  wire logic [31:0]        regWdata,
	input  wire logic               regRead,
	output logic      [31:0]        regRdata,
	input  wire logic               receiverErrorEvt,
	input  wire logic               transmitterErrorEvt,
	input  wire logic               pinEventPending,
	input  wire logic               txDataWrite,
	input  wire logic               txDataFull,
	input  wire logic [LEVEL_W-1:0] txDataFree,
	input  wire logic [LEVEL_W-1:0] txDataSpaceLevel,
	input  wire logic               txStatusFull,
	input  wire logic [LEVEL_W-1:0] txStatusCount,
	input  wire logic [LEVEL_W-1:0] txStatusLevel,
	input  wire logic               rxFrameDropped,
	input  wire logic               rxStatusWrite,
	input  wire logic               rxStatusFull,
	input  wire logic [LEVEL_W-1:0] rxStatusCount,
	input  wire logic [LEVEL_W-1:0] rxStatusLevel,
	output logic                    irq
);

	initial begin
		if (LEVEL_W < 1 || LEVEL_W > 16) begin
			$error("LEVEL_W must be 1 to 16");
		end
	end

	function automatic logic atOrAbove(input logic [LEVEL_W-1:0] count, input logic [LEVEL_W-1:0] level);
		atOrAbove = (count >= level);
	endfunction

	logic [31:0] enable_reg;
	logic [31:0] enable_next;
	logic [31:0] status_reg;
	logic [31:0] status_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic        irq_reg;
	logic        irq_next;

	logic        txSpaceRise;
	logic        txsFullRise;
	logic        txsLevelRise;
	logic        rxsLevelRise;
	logic        softRise;
	logic [31:0] setVec;
	logic [31:0] statusView;
	logic        wrStatus;
	logic        wrEnable;

	assign wrStatus = regWrite && (regAddr == OFF_STATUS);
	assign wrEnable = regWrite && (regAddr == OFF_ENABLE);

	// threshold and full conditions count once at their onset
	hise_rise_detect u_txSpace (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.condIn    (txDataFree > txDataSpaceLevel), // RULE5
		.risePulse (txSpaceRise)
	);

	hise_rise_detect u_txsFull (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.condIn    (txStatusFull), // RULE6
		.risePulse (txsFullRise)
	);

	hise_rise_detect u_txsLevel (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.condIn    (atOrAbove(txStatusCount, txStatusLevel)), // RULE7
		.risePulse (txsLevelRise)
	);

	hise_rise_detect u_rxsLevel (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.condIn    (atOrAbove(rxStatusCount, rxStatusLevel)), // RULE10
		.risePulse (rxsLevelRise)
	);

	// software bit follows the enable going high
	hise_rise_detect u_soft (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.condIn    (enable_reg[BIT_SOFT_IRQ]), // RULE15
		.risePulse (softRise)
	);

	// set sources, independent of the enables except the software bit, which follows its enable
	always_comb begin
		setVec                 = 32'h00000000;
		setVec[BIT_RX_ERROR]   = receiverErrorEvt; // RULE1 RULE12
		setVec[BIT_TX_ERROR]   = transmitterErrorEvt; // RULE2
		setVec[BIT_TX_OVERRUN] = txDataWrite & txDataFull; // RULE4
		setVec[BIT_TX_SPACE]   = txSpaceRise; // RULE5
		setVec[BIT_TXS_FULL]   = txsFullRise; // RULE6
		setVec[BIT_TXS_LEVEL]  = txsLevelRise; // RULE7
		setVec[BIT_RX_DROPPED] = rxFrameDropped; // RULE8
		setVec[BIT_RXS_FULL]   = rxStatusWrite & rxStatusFull; // RULE9
		setVec[BIT_RXS_LEVEL]  = rxsLevelRise; // RULE10
		setVec[BIT_SOFT_IRQ]   = softRise; // RULE15
	end

	// status: write one clears, zero leaves, a set in the same cycle wins
	always_comb begin
		status_next = status_reg;
		if (wrStatus) begin
			status_next = status_next & ~(regWdata & STATUS_W1C_MASK); // RULE16 RULE1 RULE2
		end
		status_next = (status_next | setVec) & STATUS_W1C_MASK;
	end

	// live view adds the read-only pin event summary
	always_comb begin
		statusView                = status_reg;
		statusView[BIT_PIN_EVENT] = pinEventPending; // RULE3
	end

	// enables: reserved positions never store a one
	always_comb begin
		enable_next = enable_reg;
		if (wrEnable) begin
			enable_next = regWdata & ENABLE_WR_MASK; // RULE11 RULE13
		end
	end

	// registered read data; unmapped addresses read zero
	always_comb begin
		rdata_next = rdata_reg;
		if (regRead) begin
			case (regAddr)
				OFF_STATUS: begin
					rdata_next = statusView;
				end
				OFF_ENABLE: begin
					rdata_next = enable_reg;
				end
				default: begin
					rdata_next = 32'h00000000;
				end
			endcase
		end
	end

	always_comb begin
		irq_next = |(statusView & enable_reg); // RULE17 RULE11
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			enable_reg <= ENABLE_RESET; // RULE14
			status_reg <= STATUS_RESET;
			rdata_reg  <= RDATA_RESET;
			irq_reg    <= 1'b0;
		end else begin
			enable_reg <= enable_next;
			status_reg <= status_next;
			rdata_reg  <= rdata_next;
			irq_reg    <= irq_next;
		end
	end

	assign regRdata = rdata_reg;
	assign irq      = irq_reg;

endmodule // hise_irq_ctrl

`default_nettype wire

//--- rtl/hise_pkg.sv
package hise_pkg;

	// register map, byte addresses on the internal dword register port
	localparam int          ADDR_W          = 10;
	localparam logic [9:0]  OFF_STATUS      = 10'h058;
	localparam logic [9:0]  OFF_ENABLE      = 10'h05C;

	// status and enable bit positions
	localparam int          BIT_SOFT_IRQ    = 31;
	localparam int          BIT_RX_ERROR    = 14;
	localparam int          BIT_TX_ERROR    = 13;
	localparam int          BIT_PIN_EVENT   = 12;
	localparam int          BIT_TX_OVERRUN  = 10;
	localparam int          BIT_TX_SPACE    = 9;
	localparam int          BIT_TXS_FULL    = 8;
	localparam int          BIT_TXS_LEVEL   = 7;
	localparam int          BIT_RX_DROPPED  = 6;
	localparam int          BIT_RXS_FULL    = 4;
	localparam int          BIT_RXS_LEVEL   = 3;

	// writable enable bits: all but reserved 28:27, 22, 18, 11, 5, 2:0
	localparam logic [31:0] ENABLE_WR_MASK  = 32'hE7BBF7D8;
	// status bits held in this block and cleared by writing one
	localparam logic [31:0] STATUS_W1C_MASK = 32'h800067D8;

	// values after reset
	localparam logic [31:0] ENABLE_RESET    = 32'h00000000;
	localparam logic [31:0] STATUS_RESET    = 32'h00000000;
	localparam logic [31:0] RDATA_RESET     = 32'h00000000;

	// default width of fifo levels and thresholds
	localparam int          LEVEL_W_DEFAULT = 16;

endpackage : hise_pkg

//--- rtl/hise_rise_detect.sv
`timescale 1ns/1ns
`default_nettype none

module hise_rise_detect (
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic condIn,
	output logic      risePulse
);

	logic condLast_reg;
	logic condLast_next;

	// remembers the condition so only its onset counts as an event
	always_comb begin
		condLast_next = condIn;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			condLast_reg <= 1'b0;
		end else begin
			condLast_reg <= condLast_next;
		end
	end

	assign risePulse = condIn & ~condLast_reg;

endmodule // hise_rise_detect

`default_nettype wire

//--- dv/hise_irq_checker.sv
`timescale 1ns/1ns
`default_nettype none
module hise_irq_checker
	import hise_pkg::*;
(
	input wire logic              clk_sys,
	input wire logic              rst_n,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic              regWrite,
	input wire logic [31:0]       regWdata,
	input wire logic              regRead,
	input wire logic [31:0]       regRdata,
	input wire logic              receiverErrorEvt,
	input wire logic              rxFrameDropped,
	input wire logic              irq
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	wire logic stRd = regRead && regAddr == OFF_STATUS;
	a_rx_err_set: assert property (receiverErrorEvt ##1 stRd |=> regRdata[14])
		else $error("rx error flag");
	a_drop_set: assert property (rxFrameDropped ##1 stRd |=> regRdata[6])
		else $error("drop flag");
	a_rsvd_zero: assert property (regRead && regAddr == OFF_ENABLE |=> (regRdata & ~ENABLE_WR_MASK) == 32'h0)
		else $error("reserved bits");
	a_unmapped_zero: assert property (regRead && regAddr != OFF_ENABLE && !stRd |=> regRdata == 32'h0)
		else $error("unmapped read");
	a_rdata_hold: assert property (!regRead |=> $stable(regRdata))
		else $error("read data moved");
	a_reset_quiet: assert property ($rose(rst_n) |-> !irq ##1 !irq)
		else $error("irq after reset");
	a_irq_off: assert property (regWrite && regAddr == OFF_ENABLE && regWdata == 32'h0 ##1 !regWrite |=> !irq)
		else $error("irq not dropped");
	a_clear_w1c: assert property (regWrite && regAddr == OFF_STATUS && regWdata[6] && !rxFrameDropped
		##1 !rxFrameDropped ##1 stRd |=> !regRdata[6])
		else $error("flag not cleared");
	c_irq: cover property (irq);
	c_irq_fall: cover property ($fell(irq));
	c_rx_seen: cover property (stRd ##1 regRdata[14]);
endmodule // hise_irq_checker
bind hise_irq_ctrl hise_irq_checker hise_irq_checker_i (.*);
`default_nettype wire

//--- dv/hise_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module hise_host_model
	import hise_pkg::*;
(
	input  wire logic              clk_sys,
	output logic      [ADDR_W-1:0] regAddr,
	output logic                   regWrite,
	output logic      [31:0]       regWdata,
	output logic                   regRead,
	input  wire logic [31:0]       regRdata
);
	initial begin
		{regAddr, regWrite, regWdata, regRead} = '0;
	end
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		{regAddr, regWdata, regWrite} <= {a, v, 1'b1};
		@(posedge clk_sys);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] v);
		@(posedge clk_sys);
		{regAddr, regRead} <= {a, 1'b1};
		@(posedge clk_sys);
		regRead <= 1'b0;
		#1 v = regRdata;
	endtask
endmodule // hise_host_model
`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
	import hise_pkg::*;
	typedef struct packed {logic [8:0] e; logic [3:0] f, t, r; logic [31:0] x;} hise_row_t;
	logic              clk_sys, rst_n, regWrite, regRead, irq;
	logic [8:0]        ev;
	logic [3:0]        fr, tc, rc, lv;
	logic [ADDR_W-1:0] regAddr;
	logic [31:0]       regWdata, regRdata, d;
	int                errors, checks;
	hise_row_t rows [11] = '{'{9'h001, 4'h0, 4'h0, 4'h0, 32'h00004000}, '{9'h002, 4'h0, 4'h0, 4'h0, 32'h00002000},
		'{9'h004, 4'h0, 4'h0, 4'h0, 32'h00001000}, '{9'h018, 4'h0, 4'h0, 4'h0, 32'h00000400},
		'{9'h020, 4'h0, 4'h0, 4'h0, 32'h00000100}, '{9'h040, 4'h0, 4'h0, 4'h0, 32'h00000040},
		'{9'h180, 4'h0, 4'h0, 4'h0, 32'h00000010}, '{9'h000, 4'h1, 4'h0, 4'h0, 32'h00000200},
		'{9'h000, 4'h0, 4'hF, 4'h0, 32'h00000080}, '{9'h000, 4'h0, 4'h0, 4'hF, 32'h00000008},
		'{9'h088, 4'h0, 4'hE, 4'hE, 32'h00000000}};
	hise_host_model hise_host_model_i (.*);
	hise_irq_ctrl #(.LEVEL_W(4)) hise_irq_ctrl_i (.*, .receiverErrorEvt(ev[0]), .transmitterErrorEvt(ev[1]),
		.pinEventPending(ev[2]), .txDataWrite(ev[3]), .txDataFull(ev[4]), .txStatusFull(ev[5]),
		.rxFrameDropped(ev[6]), .rxStatusWrite(ev[7]), .rxStatusFull(ev[8]), .txDataFree(fr),
		.txDataSpaceLevel(lv), .txStatusCount(tc), .txStatusLevel(4'hF), .rxStatusCount(rc), .rxStatusLevel(4'hF));
	task automatic cw(input string n, input logic [31:0] e, s);
		checks++;
		if (s !== e) begin
			errors++;
			$display("Error %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic cb(input logic e);
		cw("irq", {31'h0, e}, {31'h0, irq});
	endtask
	task give_verdict;
		if (errors == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		#20000;
		errors++;
		give_verdict;
	end
	initial begin
		{rst_n, ev, fr, tc, rc, lv} = '0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		foreach (rows[i]) begin
			@(posedge clk_sys);
			{ev, fr, tc, rc} <= {rows[i].e, rows[i].f, rows[i].t, rows[i].r};
			hise_host_model_i.rd(OFF_STATUS, d);
			cw("status", rows[i].x, d);
			@(posedge clk_sys);
			{ev, fr, tc, rc} <= '0;
			hise_host_model_i.wr(OFF_STATUS, 32'hFFFFFFFF);
			hise_host_model_i.rd(OFF_STATUS, d);
			cw("cleared", 32'h0, d);
		end
		// free space equal to the threshold must not count, one above must
		@(posedge clk_sys);
		{lv, fr} <= {4'h3, 4'h3};
		hise_host_model_i.rd(OFF_STATUS, d);
		cw("space", 32'h0, d);
		@(posedge clk_sys);
		fr <= 4'h4;
		hise_host_model_i.rd(OFF_STATUS, d);
		cw("space", 32'h00000200, d);
		hise_host_model_i.wr(OFF_STATUS, 32'hFFFFFFFF);
		hise_host_model_i.wr(OFF_ENABLE, 32'hFFFFFFFF);
		hise_host_model_i.rd(OFF_ENABLE, d);
		cw("enable", ENABLE_WR_MASK, d);
		hise_host_model_i.rd(OFF_STATUS, d);
		cw("status", 32'h80000000, d);
		cb(1'b1);
		@(posedge clk_sys);
		ev <= 9'h004;
		hise_host_model_i.wr(OFF_ENABLE, 32'h0);
		hise_host_model_i.wr(OFF_STATUS, 32'h00001000);
		hise_host_model_i.rd(OFF_STATUS, d);
		cw("status", 32'h80001000, d);
		cb(1'b0);
		hise_host_model_i.wr(OFF_STATUS, 32'h80000000);
		hise_host_model_i.wr(OFF_ENABLE, 32'h00001000);
		hise_host_model_i.rd(OFF_STATUS, d);
		cw("status", 32'h00001000, d);
		cb(1'b1);
		hise_host_model_i.rd(10'h060, d);
		cw("unmapped", 32'h0, d);
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		hise_host_model_i.rd(OFF_ENABLE, d);
		cw("enable", 32'h0, d);
		cb(1'b0);
		give_verdict;
	end
endmodule // tb
`default_nettype wire
